// File: hdl/key_check.sv
// protection key selection and violation decode for translation misses
`timescale 1ns/1ps
`default_nettype none
module key_check (
	input  wire logic       supervisor_key_i,
	input  wire logic       user_key_i,
	input  wire logic       problem_state_flag_i,
	input  wire logic [1:0] page_protection_bits_i,
	output logic            key_o,
	output logic            violation_o
);

	// key follows the privilege of the access
	assign key_o = problem_state_flag_i ? user_key_i : supervisor_key_i; // [RULE_04]

	// key only means a violation for the two lowest protection codes
	assign violation_o = key_o && ((page_protection_bits_i == mmu_fault_pkg::PROT_KEY_NONE) ||
		(page_protection_bits_i == mmu_fault_pkg::PROT_KEY_READ)); // [RULE_05]

endmodule : key_check
`default_nettype wire

// File: hdl/mmu_fault_pkg.sv
// constants, register map and types for the mmu fault and status logic
//
// Operation
// RULE_01 - split 16-Kbyte caches, four-way set associative
// RULE_02 - direct-store segment access raises data storage fault
// RULE_03 - clock config register shows strap bits 0-3
// RULE_04 - translation miss writes selected key to bit 12
// RULE_05 - key flags violation only for protection 00/01
// RULE_06 - handler leaves page-modified flag on violating miss
// RULE_07 - a store completes in a single cycle
// RULE_08 - fill forwards line, other lines fetch in parallel (code: only in enhanced mode, control bit 0; clear at reset)
// RULE_09 - misaligned little-endian loads and stores execute (code: only in enhanced mode; otherwise alignment fault)
// RULE_10 - system register unit has own adder, comparator
// RULE_11 - fill way select shows binary way index
// RULE_12 - strap sampled after reset, held, writes ignored
package mmu_fault_pkg;

	// ----------------------------------------------------------------
	// cache geometry
	// ----------------------------------------------------------------
	localparam int CACHE_BYTES = 16384;
	localparam int CACHE_WAYS  = 4;
	localparam int LINE_BYTES  = 32;
	localparam int CACHE_SETS  = CACHE_BYTES / (CACHE_WAYS * LINE_BYTES);
	localparam logic [31:0] GEOM_VALUE = {8'h00, 8'(LINE_BYTES), 8'(CACHE_WAYS),
		8'(CACHE_BYTES / 1024)};

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [9:0]  IDX_CONTROL      = 10'h000;
	localparam logic [9:0]  IDX_FAULT_STATUS = 10'h001;
	localparam logic [9:0]  IDX_CACHE_GEOM   = 10'h002;
	localparam logic [9:0]  IDX_SAVE_STATUS  = 10'h01b;
	localparam logic [9:0]  IDX_CLOCK_CONFIG = 10'h3f1;
	localparam logic [11:0] ADDR_CONTROL      = {IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_FAULT_STATUS = {IDX_FAULT_STATUS, 2'h0};
	localparam logic [11:0] ADDR_CACHE_GEOM   = {IDX_CACHE_GEOM, 2'h0};
	localparam logic [11:0] ADDR_SAVE_STATUS  = {IDX_SAVE_STATUS, 2'h0};
	localparam logic [11:0] ADDR_CLOCK_CONFIG = {IDX_CLOCK_CONFIG, 2'h0};

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int STRAP_W        = 4;
	localparam int STRAP_LSB      = 0;
	localparam int SAVE_KEY_BIT   = 12;
	localparam int CTRL_ENH_BIT   = 0;
	localparam int STAT_DSF_BIT   = 0;
	localparam int STAT_MISS_BIT  = 1;
	localparam int STAT_VIOL_BIT  = 2;
	localparam int STAT_ALIGN_BIT = 3;
	localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
	localparam logic [31:0] RST_SAVE    = 32'h0000_0000;
	localparam logic [3:0]  RST_STATUS  = 4'h0;
	localparam logic [3:0]  RST_STRAP   = 4'h0;

	// protection codes under which the key bit reports a violation
	localparam logic [1:0] PROT_KEY_NONE = 2'h0;
	localparam logic [1:0] PROT_KEY_READ = 2'h1;

	// strap capture sequence, gray coded
	typedef enum logic [1:0] {
		ST_WAIT0   = 2'h0,
		ST_WAIT1   = 2'h1,
		ST_CAPTURE = 2'h3,
		ST_HELD    = 2'h2
	} strap_state_t;

endpackage : mmu_fault_pkg

// File: hdl/mmu_fault_status_logic.sv
// mmu fault, key capture, strap readback and fetch/store control with apb registers
`timescale 1ns/1ps
`default_nettype none
module mmu_fault_status_logic (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// clock multiplier strap pins
	input  wire logic [3:0]  clk_mult_strap_i,
	// data access path
	input  wire logic        access_valid_i,
	input  wire logic        segment_direct_store_i,
	input  wire logic        access_misaligned_le_i,
	output logic             mem_req_o,
	output logic             data_storage_fault_o,
	output logic             alignment_fault_o,
	input  wire logic        store_req_i,
	output logic             store_done_o,
	// translation miss
	input  wire logic        data_translation_buffer_miss_i,
	input  wire logic        supervisor_key_i,
	input  wire logic        user_key_i,
	input  wire logic        problem_state_flag_i,
	input  wire logic [1:0]  page_protection_bits_i,
	output logic             miss_exception_o,
	output logic             key_violation_o,
	// instruction cache fill and fetch
	input  wire logic        fill_active_i,
	input  wire logic [1:0]  fill_way_i,
	input  wire logic        critical_forwarded_i,
	input  wire logic        fetch_req_i,
	input  wire logic        fetch_same_line_i,
	input  wire logic        fetch_hit_i,
	output logic [1:0]       fill_way_select_o,
	output logic             fetch_forward_o,
	output logic             fetch_grant_o,
	// system register unit lanes
	input  wire logic [1:0]  sru_valid_i,
	input  wire logic [31:0] sru0_a_i,
	input  wire logic [31:0] sru0_b_i,
	input  wire logic [31:0] sru1_a_i,
	input  wire logic [31:0] sru1_b_i,
	output logic [31:0]      sru0_sum_o,
	output logic [2:0]       sru0_cmp_o,
	output logic [31:0]      sru1_sum_o,
	output logic [2:0]       sru1_cmp_o,
	output logic [1:0]       sru_done_o
);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0]                  control_reg;
	logic [31:0]                  save_status_reg;
	logic [3:0]                   status_reg;
	logic [3:0]                   status_next;
	logic [3:0]                   strap_meta_reg;
	logic [3:0]                   strap_sync_reg;
	logic [3:0]                   strap_reg;
	mmu_fault_pkg::strap_state_t  strap_state_reg;
	logic                         enh_mode;
	logic                         key_bit;
	logic                         key_viol;
	logic                         apb_setup;
	logic                         apb_write;
	logic                         ds_hit;
	logic                         align_hit;
	logic [31:0]                  read_mux;
	logic                         read_err;

	assign enh_mode  = control_reg[mmu_fault_pkg::CTRL_ENH_BIT];
	assign apb_setup = psel_i && !penable_i;
	assign apb_write = psel_i && penable_i && pready_o && pwrite_i;
	assign ds_hit    = access_valid_i && segment_direct_store_i;
	assign align_hit = access_valid_i && !segment_direct_store_i &&
		access_misaligned_le_i && !enh_mode;

	// ----------------------------------------------------------------
	// strap synchroniser and one-time capture
	// ----------------------------------------------------------------

	// two-stage synchroniser on the strap pins
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_meta_reg <= mmu_fault_pkg::RST_STRAP;
			strap_sync_reg <= mmu_fault_pkg::RST_STRAP;
		end else begin
			strap_meta_reg <= clk_mult_strap_i;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// wait for the synchroniser to fill, capture once, then hold
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_state_reg <= mmu_fault_pkg::ST_WAIT0;
			strap_reg       <= mmu_fault_pkg::RST_STRAP;
		end else begin
			case (strap_state_reg)
				mmu_fault_pkg::ST_WAIT0: begin
					strap_state_reg <= mmu_fault_pkg::ST_WAIT1;
				end
				mmu_fault_pkg::ST_WAIT1: begin
					strap_state_reg <= mmu_fault_pkg::ST_CAPTURE;
				end
				mmu_fault_pkg::ST_CAPTURE: begin
					strap_reg       <= strap_sync_reg; // [RULE_12]
					strap_state_reg <= mmu_fault_pkg::ST_HELD;
				end
				mmu_fault_pkg::ST_HELD: begin
					strap_state_reg <= mmu_fault_pkg::ST_HELD; // [RULE_12]
				end
				default: begin
					strap_state_reg <= mmu_fault_pkg::ST_WAIT0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// key decode and add/compare lanes
	// ----------------------------------------------------------------
	key_check u_key_check (
		.supervisor_key_i       (supervisor_key_i),
		.user_key_i             (user_key_i),
		.problem_state_flag_i   (problem_state_flag_i),
		.page_protection_bits_i (page_protection_bits_i),
		.key_o                  (key_bit),
		.violation_o            (key_viol)
	);

	sru_addcmp u_sru0 (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.valid_i   (sru_valid_i[0]),
		.a_i       (sru0_a_i),
		.b_i       (sru0_b_i),
		.sum_o     (sru0_sum_o),
		.cmp_o     (sru0_cmp_o),
		.done_o    (sru_done_o[0])
	);

	sru_addcmp u_sru1 (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.valid_i   (sru_valid_i[1]),
		.a_i       (sru1_a_i),
		.b_i       (sru1_b_i),
		.sum_o     (sru1_sum_o),
		.cmp_o     (sru1_cmp_o),
		.done_o    (sru_done_o[1])
	);

	// ----------------------------------------------------------------
	// data access path
	// ----------------------------------------------------------------

	// direct-store never reaches memory; misaligned le needs enhanced mode
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem_req_o            <= 1'h0;
			data_storage_fault_o <= 1'h0;
			alignment_fault_o    <= 1'h0;
			store_done_o         <= 1'h0;
		end else begin
			mem_req_o            <= access_valid_i && !ds_hit && !align_hit; // [RULE_02] [RULE_09]
			data_storage_fault_o <= ds_hit; // [RULE_02]
			alignment_fault_o    <= align_hit; // [RULE_09]
			store_done_o         <= store_req_i; // [RULE_07]
		end
	end

	// translation miss reports the key before any table search
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			miss_exception_o <= 1'h0;
			key_violation_o  <= 1'h0;
		end else begin
			miss_exception_o <= data_translation_buffer_miss_i;
			key_violation_o  <= data_translation_buffer_miss_i && key_viol; // [RULE_05]
		end
	end

	// ----------------------------------------------------------------
	// instruction fetch during line fill
	// ----------------------------------------------------------------

	// way index on fill, forwarding and parallel hits when enhanced
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fill_way_select_o <= 2'h0;
			fetch_forward_o   <= 1'h0;
			fetch_grant_o     <= 1'h0;
		end else begin
			fill_way_select_o <= fill_active_i ? fill_way_i : 2'h0; // [RULE_11]
			fetch_forward_o   <= fetch_req_i && fill_active_i && fetch_same_line_i &&
				critical_forwarded_i && enh_mode; // [RULE_08]
			fetch_grant_o     <= fetch_req_i && fetch_hit_i && !fetch_same_line_i &&
				(!fill_active_i || enh_mode); // [RULE_08]
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------

	// control register, software steered
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			control_reg <= mmu_fault_pkg::RST_CONTROL;
		end else if (apb_write && paddr_i == mmu_fault_pkg::ADDR_CONTROL) begin
			control_reg <= pwdata_i;
		end
	end

	// save status: software write, then miss key overrides bit 12
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			save_status_reg <= mmu_fault_pkg::RST_SAVE;
		end else begin
			if (apb_write && paddr_i == mmu_fault_pkg::ADDR_SAVE_STATUS) begin
				save_status_reg <= pwdata_i;
			end
			if (data_translation_buffer_miss_i) begin
				save_status_reg[mmu_fault_pkg::SAVE_KEY_BIT] <= key_bit; // [RULE_04]
			end
		end
	end

	// sticky fault flags, write one to clear, a new event wins
	always_comb begin
		status_next = status_reg;
		if (apb_write && paddr_i == mmu_fault_pkg::ADDR_FAULT_STATUS) begin
			status_next = status_reg & ~pwdata_i[3:0];
		end
		if (ds_hit) begin
			status_next[mmu_fault_pkg::STAT_DSF_BIT] = 1'h1;
		end
		if (data_translation_buffer_miss_i) begin
			status_next[mmu_fault_pkg::STAT_MISS_BIT] = 1'h1;
		end
		if (data_translation_buffer_miss_i && key_viol) begin
			status_next[mmu_fault_pkg::STAT_VIOL_BIT] = 1'h1;
		end
		if (align_hit) begin
			status_next[mmu_fault_pkg::STAT_ALIGN_BIT] = 1'h1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_reg <= mmu_fault_pkg::RST_STATUS;
		end else begin
			status_reg <= status_next;
		end
	end

	// read decode; clock config and geometry are read only
	always_comb begin
		read_mux = 32'h0000_0000;
		read_err = 1'h0;
		case (paddr_i)
			mmu_fault_pkg::ADDR_CONTROL:      read_mux = control_reg;
			mmu_fault_pkg::ADDR_FAULT_STATUS: read_mux = {28'h000_0000, status_reg};
			mmu_fault_pkg::ADDR_CACHE_GEOM:   read_mux = mmu_fault_pkg::GEOM_VALUE; // [RULE_01]
			mmu_fault_pkg::ADDR_SAVE_STATUS:  read_mux = save_status_reg;
			mmu_fault_pkg::ADDR_CLOCK_CONFIG: read_mux = {28'h000_0000, strap_reg}; // [RULE_03]
			default:                          read_err = 1'h1;
		endcase
	end

	// apb answer: ready in the first access cycle, data latched in setup
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pready_o  <= 1'h0;
			pslverr_o <= 1'h0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= apb_setup;
			pslverr_o <= apb_setup && read_err;
			if (apb_setup) begin
				prdata_o <= (pwrite_i || read_err) ? 32'h0000_0000 : read_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ds_fault: assert property ( // [RULE_02]
		ds_hit |=> data_storage_fault_o && !mem_req_o)
		else $error("direct-store access not faulted");

	a_strap_read: assert property ( // [RULE_03]
		psel_i && penable_i && pready_o && !pwrite_i &&
		paddr_i == mmu_fault_pkg::ADDR_CLOCK_CONFIG |-> prdata_o == {28'h000_0000, strap_reg})
		else $error("clock config read wrong");

	a_strap_hold: assert property ( // [RULE_12]
		strap_state_reg == mmu_fault_pkg::ST_HELD |=> $stable(strap_reg) &&
		strap_state_reg == mmu_fault_pkg::ST_HELD)
		else $error("strap value changed while running");

	a_key_capture: assert property ( // [RULE_04]
		data_translation_buffer_miss_i |=> save_status_reg[mmu_fault_pkg::SAVE_KEY_BIT] ==
		($past(problem_state_flag_i) ? $past(user_key_i) : $past(supervisor_key_i)))
		else $error("miss key bit wrong");

	a_key_viol: assert property ( // [RULE_05]
		key_violation_o |-> $past(data_translation_buffer_miss_i) && !$past(page_protection_bits_i[1]))
		else $error("violation reported for wrong protection");

	a_store_once: assert property ( // [RULE_07]
		store_req_i |=> store_done_o)
		else $error("store not done in one cycle");

	a_fill_way: assert property ( // [RULE_11]
		fill_active_i |=> fill_way_select_o == $past(fill_way_i))
		else $error("fill way select wrong");

	a_fetch_fwd: assert property ( // [RULE_08]
		fetch_forward_o |-> $past(critical_forwarded_i) && $past(enh_mode))
		else $error("forward before critical word");

	a_misalign_ok: assert property ( // [RULE_09]
		access_valid_i && access_misaligned_le_i && !segment_direct_store_i && enh_mode
		|=> mem_req_o && !alignment_fault_o)
		else $error("misaligned le access blocked");

	a_geom_read: assert property ( // [RULE_01]
		psel_i && penable_i && pready_o && !pwrite_i &&
		paddr_i == mmu_fault_pkg::ADDR_CACHE_GEOM |-> prdata_o == mmu_fault_pkg::GEOM_VALUE)
		else $error("cache geometry read wrong");

	c_ds_fault:   cover property (ds_hit ##1 data_storage_fault_o);
	c_key_viol:   cover property (data_translation_buffer_miss_i ##1 key_violation_o);
	c_fill_par:   cover property (fetch_forward_o ##1 fetch_grant_o);
	c_strap_read: cover property (psel_i && penable_i && pready_o &&
		paddr_i == mmu_fault_pkg::ADDR_CLOCK_CONFIG);

endmodule : mmu_fault_status_logic
`default_nettype wire

// File: hdl/sru_addcmp.sv
// one add and compare lane of the system register unit
`timescale 1ns/1ps
`default_nettype none
module sru_addcmp (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        valid_i,
	input  wire logic [31:0] a_i,
	input  wire logic [31:0] b_i,
	output logic [31:0]      sum_o,
	output logic [2:0]       cmp_o,
	output logic             done_o
);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// sum plus signed less, greater, equal in one cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sum_o  <= 32'h0000_0000;
			cmp_o  <= 3'h0;
			done_o <= 1'h0;
		end else begin
			done_o <= valid_i;
			if (valid_i) begin
				sum_o <= a_i + b_i; // [RULE_10]
				cmp_o <= {$signed(a_i) < $signed(b_i), $signed(a_i) > $signed(b_i),
					a_i == b_i}; // [RULE_10]
			end
		end
	end

	a_lane_add: assert property ( // [RULE_10]
		valid_i |=> done_o && sum_o == $past(a_i) + $past(b_i))
		else $error("sru lane sum wrong");

endmodule : sru_addcmp
`default_nettype wire

// File: verification/mmu_fault_status_logic_tb.sv
// self-checking testbench for the mmu fault and status logic
`timescale 1ns/1ps
`default_nettype none
module mmu_fault_status_logic_tb;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, sru0_a_i, sru0_b_i, sru1_a_i, sru1_b_i;
	logic [31:0] sru0_sum_o, sru1_sum_o, rd;
	logic [3:0]  clk_mult_strap_i;
	logic        access_valid_i, segment_direct_store_i, access_misaligned_le_i, mem_req_o;
	logic        data_storage_fault_o, alignment_fault_o, store_req_i, store_done_o;
	logic        data_translation_buffer_miss_i, supervisor_key_i, user_key_i;
	logic        problem_state_flag_i, miss_exception_o, key_violation_o, fill_active_i;
	logic        critical_forwarded_i, fetch_req_i, fetch_same_line_i, fetch_hit_i;
	logic        fetch_forward_o, fetch_grant_o, err;
	logic [1:0]  page_protection_bits_i, fill_way_i, fill_way_select_o, sru_valid_i, sru_done_o;
	logic [2:0]  sru0_cmp_o, sru1_cmp_o;
	int          mismatches, num_checks;
	int          cycles = 0;

	mmu_fault_status_logic dut_u (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .clk_mult_strap_i(clk_mult_strap_i),
		.access_valid_i(access_valid_i), .segment_direct_store_i(segment_direct_store_i),
		.access_misaligned_le_i(access_misaligned_le_i), .mem_req_o(mem_req_o),
		.data_storage_fault_o(data_storage_fault_o), .alignment_fault_o(alignment_fault_o),
		.store_req_i(store_req_i), .store_done_o(store_done_o),
		.data_translation_buffer_miss_i(data_translation_buffer_miss_i),
		.supervisor_key_i(supervisor_key_i), .user_key_i(user_key_i),
		.problem_state_flag_i(problem_state_flag_i),
		.page_protection_bits_i(page_protection_bits_i), .miss_exception_o(miss_exception_o),
		.key_violation_o(key_violation_o), .fill_active_i(fill_active_i),
		.fill_way_i(fill_way_i), .critical_forwarded_i(critical_forwarded_i),
		.fetch_req_i(fetch_req_i), .fetch_same_line_i(fetch_same_line_i),
		.fetch_hit_i(fetch_hit_i), .fill_way_select_o(fill_way_select_o),
		.fetch_forward_o(fetch_forward_o), .fetch_grant_o(fetch_grant_o),
		.sru_valid_i(sru_valid_i), .sru0_a_i(sru0_a_i), .sru0_b_i(sru0_b_i),
		.sru1_a_i(sru1_a_i), .sru1_b_i(sru1_b_i), .sru0_sum_o(sru0_sum_o),
		.sru0_cmp_o(sru0_cmp_o), .sru1_sum_o(sru1_sum_o), .sru1_cmp_o(sru1_cmp_o),
		.sru_done_o(sru_done_o)
	);

	// ----------------------------------------------------------------
	// clock, timeout and helper tasks
	// ----------------------------------------------------------------
	// 50 ns period
	always #25 clk_i = ~clk_i;

	// hang guard, far above the expected run length
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 4000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : chk_bit

	// one apb transfer: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i    <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1);
		rd        = prdata_o;
		err       = pslverr_o;
		chk_word("pready wait", 32'h0000_0001, 32'(n));
		psel_i    <= 1'h0;
		penable_i <= 1'h0;
	endtask : apb

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		{clk_i, reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{access_valid_i, segment_direct_store_i, access_misaligned_le_i, store_req_i} = '0;
		{data_translation_buffer_miss_i, supervisor_key_i, user_key_i} = '0;
		{problem_state_flag_i, page_protection_bits_i, fill_active_i, fill_way_i} = '0;
		{critical_forwarded_i, fetch_req_i, fetch_same_line_i, fetch_hit_i} = '0;
		{sru_valid_i, sru0_a_i, sru0_b_i, sru1_a_i, sru1_b_i} = '0;
		clk_mult_strap_i = 4'ha;
		mismatches = 0;
		num_checks = 0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		// reset values and geometry
		apb(1'h0, mmu_fault_pkg::ADDR_CONTROL, 32'h0000_0000);
		chk_word("control", mmu_fault_pkg::RST_CONTROL, rd);
		apb(1'h0, mmu_fault_pkg::ADDR_SAVE_STATUS, 32'h0000_0000);
		chk_word("save status", mmu_fault_pkg::RST_SAVE, rd);
		apb(1'h0, mmu_fault_pkg::ADDR_CACHE_GEOM, 32'h0000_0000);
		chk_word("geometry", 32'h0020_0410, rd);
		// strap readback, then write and pin change are both ignored
		apb(1'h0, mmu_fault_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0000);
		chk_word("clock config", 32'h0000_000a, rd);
		clk_mult_strap_i <= 4'h5;
		apb(1'h1, mmu_fault_pkg::ADDR_CLOCK_CONFIG, 32'hffff_ffff);
		apb(1'h0, mmu_fault_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0000);
		chk_word("clock config held", 32'h0000_000a, rd);
		// unmapped address is refused
		apb(1'h0, 12'h100, 32'h0000_0000);
		chk_bit("slverr", 1'h1, err);
		chk_word("unmapped data", 32'h0000_0000, rd);
		// direct-store access faults, the plain access after it goes to memory
		@(posedge clk_i) {access_valid_i, segment_direct_store_i} <= 2'h3;
		@(posedge clk_i) segment_direct_store_i <= 1'h0;
		#1 chk_bit("ds fault", 1'h1, data_storage_fault_o);
		chk_bit("ds mem req", 1'h0, mem_req_o);
		@(posedge clk_i) access_valid_i <= 1'h0;
		#1 chk_bit("plain mem req", 1'h1, mem_req_o);
		apb(1'h0, mmu_fault_pkg::ADDR_FAULT_STATUS, 32'h0000_0000);
		chk_bit("ds status", 1'h1, rd[mmu_fault_pkg::STAT_DSF_BIT]);
		apb(1'h1, mmu_fault_pkg::ADDR_FAULT_STATUS, 32'h0000_000f);
		apb(1'h0, mmu_fault_pkg::ADDR_FAULT_STATUS, 32'h0000_0000);
		chk_word("status cleared", 32'h0000_0000, rd);
		// misaligned little-endian access, without and with the enhanced mode
		for (int e = 0; e < 2; e++) begin
			apb(1'h1, mmu_fault_pkg::ADDR_CONTROL, 32'(e));
			@(posedge clk_i) {access_valid_i, access_misaligned_le_i} <= 2'h3;
			@(posedge clk_i) {access_valid_i, access_misaligned_le_i} <= 2'h0;
			#1 chk_bit("align fault", e == 0, alignment_fault_o);
			if (e == 1) chk_bit("align mem req", 1'h1, mem_req_o);
		end
		// fetch during a fill: forward from the filling line, grant another line
		@(posedge clk_i) {fill_active_i, critical_forwarded_i, fetch_req_i} <= 3'h7;
		fetch_same_line_i <= 1'h1;
		@(posedge clk_i) {fetch_same_line_i, fetch_hit_i} <= 2'h1;
		#1 chk_bit("forward", 1'h1, fetch_forward_o);
		@(posedge clk_i) fetch_req_i <= 1'h0;
		#1 chk_bit("grant", 1'h1, fetch_grant_o);
		chk_bit("no forward", 1'h0, fetch_forward_o);
		// fill way select shows the way index for every way
		for (int w = 0; w < 4; w++) begin
			@(posedge clk_i) fill_way_i <= 2'(w);
			@(posedge clk_i) #1 chk_word("way select", 32'(w), 32'(fill_way_select_o));
		end
		// back-to-back stores each complete in one cycle
		@(posedge clk_i) store_req_i <= 1'h1;
		fill_active_i <= 1'h0;
		@(posedge clk_i) #1 chk_bit("store done 1", 1'h1, store_done_o);
		@(posedge clk_i) store_req_i <= 1'h0;
		#1 chk_bit("store done 2", 1'h1, store_done_o);
		@(posedge clk_i) #1 chk_bit("store idle", 1'h0, store_done_o);
		chk_word("way idle", 32'h0000_0000, 32'(fill_way_select_o));
		// both system register lanes add and compare in the same cycle
		@(posedge clk_i) sru_valid_i <= 2'h3;
		{sru0_a_i, sru0_b_i, sru1_a_i, sru1_b_i} <= {32'hffff_ffff, 32'h0000_0001,
			32'h0000_0005, 32'h0000_0005};
		@(posedge clk_i) sru_valid_i <= 2'h0;
		#1 chk_word("lane done", 32'h0000_0003, 32'(sru_done_o));
		chk_word("lane0 sum", 32'h0000_0000, sru0_sum_o);
		chk_word("lane0 cmp", 32'h0000_0004, 32'(sru0_cmp_o));
		chk_word("lane1 sum", 32'h0000_000a, sru1_sum_o);
		chk_word("lane1 cmp", 32'h0000_0001, 32'(sru1_cmp_o));
		// every key, state flag and protection code on a translation miss
		// the bench stands for the handler and never touches a page-modified flag
		for (int i = 0; i < 32; i++) begin
			logic k;
			k = i[0] ? i[2] : i[1];
			@(posedge clk_i) data_translation_buffer_miss_i <= 1'h1;
			{user_key_i, supervisor_key_i, problem_state_flag_i} <= 3'(i);
			page_protection_bits_i <= 2'(i >> 3);
			@(posedge clk_i) data_translation_buffer_miss_i <= 1'h0;
			#1 chk_bit("miss exception", 1'h1, miss_exception_o);
			chk_bit("key violation", k && (i >> 3) < 2, key_violation_o);
			apb(1'h0, mmu_fault_pkg::ADDR_SAVE_STATUS, 32'h0000_0000);
			chk_bit("saved key", k, rd[mmu_fault_pkg::SAVE_KEY_BIT]);
		end
		close_out();
	end

endmodule : mmu_fault_status_logic_tb
`default_nettype wire
